// [cfs_defines.svh]
// Constants for the credit flow stream source
`ifndef CFS_DEFINES_SVH
`define CFS_DEFINES_SVH
`define CFS_CREDIT_LIMIT_DEF 256
`define CFS_CREDIT_LIMIT_MAX 256
`define CFS_CREDIT_LIMIT_MIN 1
`define CFS_SYMBOL_BITS_DEF 8
`define CFS_SYMBOLS_DEF 4
`define CFS_DATA_MAX 8192
`define CFS_ERROR_BITS_DEF 1
`define CFS_ERROR_MAX 256
`define CFS_CREDIT_RESET 0
`endif

// [cfs_pkg.sv]
// Types for the credit flow stream source
`default_nettype none
package cfs_pkg;
	typedef enum logic [2:0] {
		CFS_IDLE = 3'b001,
		CFS_SEND = 3'b010,
		CFS_DRAIN = 3'b100
	} cfs_state_e;
endpackage
`default_nettype wire

// [cfs_sink_model.sv]
// Credit granting sink model facing the stream source
`default_nettype none
module cfs_sink_model (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [8:0] grant_i,
	input wire logic valid_i,
	input wire logic return_i,
	output logic update_o,
	output logic [8:0] credit_o,
	output logic fault_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int owed;
	int left;
	assign left = owed - int'(valid_i) - int'(return_i);
	always @(posedge core_clk_i)
	begin
		update_o <= nrst_i && grant_i != 9'h0;
		credit_o <= grant_i != 9'h0 ? grant_i : nrst_i ? ~credit_o : 9'h0aa;
		fault_o <= nrst_i && left < 0;
		owed <= !nrst_i ? 0 : left + (update_o ? int'(credit_o) : 0);
	end
endmodule // cfs_sink_model
`default_nettype wire

// [cfs_source.sv]
// Credit-based stream source: credit counter, beat and return-credit logic
`include "cfs_defines.svh"
`default_nettype none

module cfs_source
	import cfs_pkg::*;
#(
	parameter int SYMBOL_BITS = `CFS_SYMBOL_BITS_DEF,
	parameter int SYMBOLS = `CFS_SYMBOLS_DEF,
	parameter int ERROR_BITS = `CFS_ERROR_BITS_DEF,
	parameter bit PACKETS = 1'b1,
	parameter int CREDIT_LIMIT = `CFS_CREDIT_LIMIT_DEF,
	parameter int DATA_BITS = SYMBOL_BITS * SYMBOLS,
	parameter int CREDIT_BITS = $clog2(CREDIT_LIMIT + 1)
)
(
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// User side
	input wire logic user_valid_i,
	input wire logic [DATA_BITS-1:0] user_data_i,
	input wire logic [ERROR_BITS-1:0] user_error_i,
	input wire logic user_sop_i,
	input wire logic user_eop_i,
	input wire logic user_return_i,
	output logic user_ready_o,
	output logic user_return_done_o,
	output logic [CREDIT_BITS-1:0] credit_count_o,
	// Link side
	input wire logic update_i,
	input wire logic [CREDIT_BITS-1:0] credit_i,
	output logic valid_o,
	output logic [DATA_BITS-1:0] data_o,
	output logic [ERROR_BITS-1:0] error_o,
	output logic sop_o,
	output logic eop_o,
	output logic return_credit_o
);

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	if (CREDIT_LIMIT < `CFS_CREDIT_LIMIT_MIN ||
		CREDIT_LIMIT > `CFS_CREDIT_LIMIT_MAX)
	begin : g_bad_limit
		$error("credit limit out of range");
	end
	if (CREDIT_BITS < 1 || CREDIT_BITS > 9)
	begin : g_bad_cbits
		$error("credit bus width out of range");
	end
	if (DATA_BITS < 1 || DATA_BITS > `CFS_DATA_MAX ||
		DATA_BITS != SYMBOL_BITS * SYMBOLS)
	begin : g_bad_data
		$error("data width out of range");
	end
	if (ERROR_BITS < 1 || ERROR_BITS > `CFS_ERROR_MAX)
	begin : g_bad_err
		$error("error width out of range");
	end

	// ------------------------------------------------------------
	// Credit bookkeeping
	// ------------------------------------------------------------
	logic [CREDIT_BITS:0] count_q;
	logic [CREDIT_BITS:0] count_d;
	logic [CREDIT_BITS:0] avail;
	logic [CREDIT_BITS:0] gained;
	logic send;
	logic give;
	logic [1:0] spent;
	logic [CREDIT_BITS:0] limit_w;

	assign limit_w = (CREDIT_BITS+1)'(CREDIT_LIMIT);
	// Credit bus is read only in update cycles
	assign gained = update_i ? {1'b0, credit_i} : '0;
	assign avail = count_q + gained;
	// Beat always has priority over a return; neither goes while the credit count is zero
	assign send = user_valid_i && (count_q != '0);
	assign give = user_return_i && !send &&
		(count_q != '0);
	assign spent = {1'b0, send} + {1'b0, give};
	assign count_d = sat_sub(avail, spent);

	function automatic logic [CREDIT_BITS:0] sat_sub(
		input logic [CREDIT_BITS:0] a,
		input logic [1:0] b
	);
		logic [CREDIT_BITS:0] r;
		r = (a > (CREDIT_BITS+1)'(b)) ? a - (CREDIT_BITS+1)'(b) : '0;
		if (r > limit_w)
		begin
			r = limit_w;
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Output state
	// ------------------------------------------------------------
	cfs_state_e state_q;
	cfs_state_e state_d;

	always_comb
	begin
		case (state_q)
			CFS_IDLE: state_d = send ? CFS_SEND : CFS_IDLE;
			CFS_SEND: state_d = send ? CFS_SEND :
				(count_d == '0 ? CFS_DRAIN : CFS_IDLE);
			CFS_DRAIN: state_d = send ? CFS_SEND : CFS_IDLE;
			default: state_d = CFS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			count_q <= (CREDIT_BITS+1)'(`CFS_CREDIT_RESET);
			state_q <= CFS_IDLE;
			valid_o <= 1'b0;
			data_o <= '0;
			error_o <= '0;
			sop_o <= 1'b0;
			eop_o <= 1'b0;
			return_credit_o <= 1'b0;
			user_return_done_o <= 1'b0;
			user_ready_o <= 1'b0;
			credit_count_o <= '0;
		end
		else
		begin
			count_q <= count_d;
			state_q <= state_d;
			valid_o <= send;
			return_credit_o <= give;
			user_return_done_o <= give;
			user_ready_o <= count_d != '0;
			credit_count_o <= count_d[CREDIT_BITS-1:0];
			// Sideband is held quiet outside valid beats
			data_o <= send ? user_data_i : '0;
			error_o <= send ? user_error_i : '0;
			sop_o <= send && PACKETS && user_sop_i;
			eop_o <= send && PACKETS && user_eop_i;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_valid_needs_credit: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		valid_o |-> $past(count_q) != '0)
		else $error("valid without credit");
	a_update_adds: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		update_i && !user_valid_i && !user_return_i &&
		(count_q + credit_i <= limit_w)
		|=> count_q == $past(count_q) + $past(credit_i))
		else $error("update did not add credit");
	a_no_update_hold: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		!update_i && !user_valid_i && !user_return_i
		|=> count_q == $past(count_q))
		else $error("credit changed without update");
	a_return_one: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		give && !update_i |=> count_q == $past(count_q) - 1)
		else $error("return did not spend one credit");
	a_beat_spends: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		send && !update_i |=> count_q == $past(count_q) - 1)
		else $error("beat did not spend one credit");
	a_ret_pulse: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		return_credit_o |-> !valid_o)
		else $error("return and beat together");
	a_reset_zero: assert property (
		@(posedge core_clk_i)
		!nrst_i |=> count_q == '0 && !valid_o)
		else $error("credit not zero after reset");
	a_side_quiet: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		!valid_o |-> !sop_o && !eop_o && error_o == '0)
		else $error("sideband active without valid");
	a_no_frame: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		!PACKETS |-> !sop_o && !eop_o)
		else $error("framing on unframed link");
	a_beat_data: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		send |=> valid_o && data_o == $past(user_data_i))
		else $error("beat data not registered");

	// ------------------------------------------------------------
	// Output and state checks
	// ------------------------------------------------------------
	a_ready_mirror: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		user_ready_o == (count_q != '0))
		else $error("ready does not match credit count");

	a_count_mirror: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		credit_count_o == count_q[CREDIT_BITS-1:0])
		else $error("shown count does not match counter");

	a_count_limit: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		count_q <= limit_w)
		else $error("credit count above limit");

	a_return_done: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		user_return_done_o == return_credit_o)
		else $error("return done differs from return strobe");

	a_ret_credit: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		return_credit_o |-> $past(count_q) != '0)
		else $error("return without credit");

	a_ret_taken: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		give |=> return_credit_o && !valid_o)
		else $error("taken return not signalled");

	a_valid_state: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		valid_o == (state_q == CFS_SEND))
		else $error("valid and state disagree");

	a_drain_empty: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		state_q == CFS_DRAIN |-> count_q == '0)
		else $error("drain state with credits left");

	a_state_onehot: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		$onehot(state_q))
		else $error("state not one-hot");

	a_empty_no_beat: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		count_q == '0 |=> !valid_o)
		else $error("beat sent with no credit");

	a_error_reg: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		send |=> error_o == $past(user_error_i))
		else $error("beat error mask not registered");

	a_sop_reg: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		send && PACKETS |=> sop_o == $past(user_sop_i))
		else $error("start mark not registered");

	a_eop_reg: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		send && PACKETS |=> eop_o == $past(user_eop_i))
		else $error("end mark not registered");

	a_quiet_data: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		!valid_o |-> data_o == '0)
		else $error("data active without valid");

	a_update_sat: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		update_i && !user_valid_i && !user_return_i &&
		(count_q + credit_i > limit_w) |=> count_q == limit_w)
		else $error("credit count not held at limit");

	a_update_spend: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		send && update_i && (count_q + credit_i <= limit_w)
		|=> count_q == $past(count_q) + $past(credit_i) - 1)
		else $error("update with beat miscounted");

	a_ret_refused: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		user_return_i && (send || count_q == '0)
		|=> !return_credit_o)
		else $error("return taken when refused");

	a_idle_quiet: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		state_q == CFS_IDLE |-> !valid_o)
		else $error("valid while idle");

endmodule // cfs_source
`default_nettype wire

// [tb.sv]
// Self-checking bench for the credit stream source
`default_nettype none
module tb;
	import cfs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic nrst, uv, ues, us, ue, ur, rdy, upd, v, es, s, e, rc, flt;
	logic [31:0] ud, d, ed;
	logic [8:0] cr, cnt_o, gr;
	logic ev = 1'b0, eer = 1'b0, eret = 1'b0, esop = 1'b0, eeop = 1'b0;
	int cnt = 0, err_count = 0, checks = 0, seed = 32'h36122b04;
	logic beat, ret, rd;
	always #4 clk = ~clk;
	cfs_source cfs_source_i (.core_clk_i(clk), .nrst_i(nrst),
		.user_valid_i(uv), .user_data_i(ud), .user_error_i(ues),
		.user_sop_i(us), .user_eop_i(ue), .user_return_i(ur),
		.user_ready_o(rdy), .user_return_done_o(rd), .credit_count_o(cnt_o),
		.update_i(upd), .credit_i(cr), .valid_o(v), .data_o(d),
		.error_o(es), .sop_o(s), .eop_o(e), .return_credit_o(rc));
	cfs_sink_model cfs_sink_model_i (.core_clk_i(clk), .nrst_i(nrst),
		.grant_i(gr), .valid_i(v), .return_i(rc), .update_o(upd),
		.credit_o(cr), .fault_o(flt));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk)
	begin
		beat = nrst && uv && cnt != 0;
		ret = nrst && ur && !beat && cnt != 0;
		cnt = !nrst ? 0 : cnt + (upd ? int'(cr) : 0) - int'(beat) - int'(ret);
		if (cnt > 256)
			cnt = 256;
		ev = beat;
		eret = ret;
		ed = beat ? ud : 32'h0;
		eer = beat & ues;
		esop = beat & us;
		eeop = beat & ue;
	end
	always @(negedge clk)
	begin
		chk(v, ev);
		chk(d, ed);
		chk({es, s, e}, {eer, esop, eeop});
		chk(rc, eret);
		chk(rd, eret);
		chk(cnt_o, cnt);
		chk(rdy, cnt != 0);
		chk(flt, 1'b0);
	end
	initial
	begin
		{nrst, uv, ues, us, ue, ur, ud, gr} <= '0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 3000; i++)
		begin
			@(posedge clk);
			uv <= i >= 1000 && i < 1500 || ($random(seed) & 3) != 0;
			ur <= ($random(seed) & 7) == 0;
			ud <= $random(seed);
			{ues, us, ue} <= 3'($random(seed));
			gr <= i == 1500 ? 9'h100 :
				(i < 1000 && ($random(seed) & 7) == 0 || i > 1500 && i[0]) ?
				9'(($random(seed) & 255) + 1) : 9'h0;
			nrst <= i != 2500;
		end
		end_sim();
	end
endmodule // tb
`default_nettype wire
